//--- common/hsp_pkg.sv
// shared constants and types of the host serial access port
package hsp_pkg;
  // ----------------------------------------------------------------
  // framing
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam logic [3:0] BYTE_MARK = 4'h8; // bits in a short frame
  localparam logic [3:0] WORD_LAST = 4'hF; // last bit of a word
  localparam logic [3:0] NEXT_FETCH = 4'hF; // link takes next tx word
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_PS = 8000;
  localparam int GLITCH_NS = 50;
  // cycles a glitch may span; a kept level must outlast them
  localparam int GLITCH_CYC = (GLITCH_NS * 1000 + SYS_PERIOD_PS - 1)
                              / SYS_PERIOD_PS;
  localparam int GLITCH_CNT_W = 4;

  // ----------------------------------------------------------------
  // receive carrier, i2c pin pair and framing states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;      // one-cycle pulse
    logic is_byte;    // short 8-bit frame closed by chip select
    logic [15:0] data;
  } hsp_rx_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } hsp_i2c_pins_t;

  typedef enum logic [2:0] {
    HSP_OFF   = 3'b001,
    HSP_IDLE  = 3'b010,
    HSP_FRAME = 3'b100
  } hsp_state_t;
endpackage : hsp_pkg

//--- dv/hsp_host_model.sv
// host processor model: spi master on the host pins
`timescale 1ns/1ps
module hsp_host_model (
  // host pins
  output logic host_clk,
  output logic host_chip_select_n,
  output logic host_serial_in,
  input wire logic host_serial_out,
  input wire logic host_serial_out_en
);
  int half = 20; // half link period in ns
  logic [31:0] got; // bits seen at rising clock, x when undriven
  // idle: clock stands low, deselected
  initial begin
    host_clk = 0;
    host_chip_select_n = 1;
    host_serial_in = 0;
  end
  // one select-low period of n bits, clock stops high at bit stop and low at stop+1
  task automatic frame(input int n, input logic [31:0] d, input int stop);
    got = '0;
    #3; // keep select off the system clock edge
    host_chip_select_n = 0;
    #(half);
    for (int i = 0; i < n; i++) begin
      host_serial_in = d[31-i];
      #(half);
      host_clk = 1;
      got[31-i] = host_serial_out_en ? host_serial_out : 1'bx;
      if (i == stop) #400;
      #(half);
      host_clk = 0;
      if (i == stop + 1) #400;
    end
    #(half);
    host_chip_select_n = 1;
    host_serial_in = ~host_serial_in; // no stale bit after release
    #100;
  endtask : frame
  // single clock pulse of w ns
  task automatic pulse(input int w);
    host_clk = 1;
    #(w);
    host_clk = 0;
  endtask : pulse
endmodule : hsp_host_model

//--- dv/hsp_host_monitor.sv
// assertions on the host port pins and receive side
`timescale 1ns/1ps
module hsp_host_monitor (
  // clock, reset and mode
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic i2c_mode,
  // host pins
  input wire logic host_clk,
  input wire logic host_chip_select_n,
  input wire logic host_serial_in,
  input wire logic host_serial_out,
  input wire logic host_serial_out_en,
  // core side
  input wire hsp_pkg::hsp_rx_t rx,
  input wire logic frame_abort,
  input wire logic [15:0] tx_word,
  input wire logic tx_take,
  input wire hsp_pkg::hsp_i2c_pins_t i2c_pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // output drive and framing relations
  release_out_a: assert property (
    host_chip_select_n |-> !host_serial_out_en)
    else $error("output driven while deselected");
  i2c_silent_a: assert property (
    i2c_mode |-> !host_serial_out_en)
    else $error("output driven in i2c mode");
  word_pulse_a: assert property (rx.valid |=> !rx.valid)
    else $error("word pulse too long");
  abort_pulse_a: assert property (frame_abort |=> !frame_abort)
    else $error("abort pulse too long");
  abort_end_a: assert property (
    frame_abort |-> host_chip_select_n && !rx.valid)
    else $error("abort outside frame end");
  byte_end_a: assert property (
    rx.valid && rx.is_byte |-> $past(host_chip_select_n, 2))
    else $error("byte before select rise");
  spi_pins_a: assert property (
    !i2c_mode [*3] |-> i2c_pins == 2'b11)
    else $error("i2c pins move in spi mode");
  i2c_no_rx_a: assert property (
    i2c_mode [*3] |-> !rx.valid && !frame_abort)
    else $error("spi traffic in i2c mode");
  take_pulse_a: assert property (tx_take |=> !tx_take)
    else $error("take pulse too long");
  c_word: cover property (rx.valid && !rx.is_byte);
  c_byte: cover property (rx.valid && rx.is_byte);
  c_abort: cover property (frame_abort);
  c_take: cover property (tx_take);
endmodule : hsp_host_monitor

bind hsp_host_port hsp_host_monitor u_mon (.*);

//--- dv/tb_top.sv
// self-checking bench for the host serial access port
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 0;
  logic rst_n = 1'b1;
  logic i2c_mode = 0;
  logic [15:0] tx_word = 16'h0000;
  logic host_clk, host_chip_select_n, host_serial_in;
  logic host_serial_out, host_serial_out_en, frame_abort, tx_take;
  hsp_pkg::hsp_rx_t rx;
  hsp_pkg::hsp_i2c_pins_t i2c_pins;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int takes = 0;
  int scl_high = 0;
  logic [17:0] exp_q[$];
  int lens[8] = '{16, 32, 8, 5, 20, 16, 1, 32};
  int stops[8] = '{-9, -9, -9, -9, -9, 6, -9, 10};

  always #4 clk_sys = ~clk_sys;
  hsp_host_port DUT (.*);
  hsp_host_model HOST (.*);

  task automatic stop_test();
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk_rx(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: rx %h expected %h", $time, got, exp);
    end
  endtask : chk_rx

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: pins %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  // receive result as one code: abort, byte or word
  function automatic logic [17:0] rx_code();
    if (frame_abort)
      return 18'h2_0000;
    if (rx.is_byte)
      return {2'b01, 8'h00, rx.data[7:0]};
    return {2'b00, rx.data};
  endfunction : rx_code

  // next reference entry, or an impossible code if none is due
  function automatic logic [17:0] rx_expect();
    if (exp_q.size() == 0)
      return 18'h3_ffff;
    return exp_q.pop_front();
  endfunction : rx_expect

  // cycle ceiling and receive results against the reference queue
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (tx_take)
      takes <= takes + 1;
    if (rx.valid || frame_abort)
      chk_rx(rx_code(), rx_expect());
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  // one frame with reference entries and returned-bit checks
  task automatic run(input int n, input int stop);
    logic [31:0] d;
    logic [15:0] a, b;
    int t0;
    d = $urandom;
    a = $urandom;
    b = $urandom;
    @(posedge clk_sys);
    tx_word <= a;
    repeat (5) @(posedge clk_sys);
    if (!i2c_mode) begin
      for (int w = 0; w < n / 16; w++)
        exp_q.push_back({2'b00, d[31-16*w -: 16]});
      if (n == 8)
        exp_q.push_back({2'b01, 8'h00, d[31:24]});
      else if (n % 16 != 0)
        exp_q.push_back(18'h2_0000);
    end
    t0 = takes;
    fork
      HOST.frame(n, d, stop);
      begin
        repeat (4) @(posedge clk_sys);
        tx_word <= b;
      end
    join
    chk_out(takes - t0, i2c_mode ? 0 : (n + 8) / 16);
    if (!i2c_mode && n >= 16)
      chk_out(HOST.got[31:16], a);
    if (!i2c_mode && n == 32)
      chk_out(HOST.got[15:0], b);
  endtask : run

  // main sequence
  initial begin
    void'($urandom(32'ha96411a5));
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1;
    repeat (4) @(posedge clk_sys);
    foreach (lens[i]) run(lens[i], stops[i]);
    i2c_mode <= 1;
    repeat (8) @(posedge clk_sys);
    run(16, -9);
    chk_out(HOST.got, {16'hxxxx, 16'h0000});
    @(posedge clk_sys);
    #7;
    HOST.pulse(hsp_pkg::GLITCH_NS);
    repeat (24) begin
      @(posedge clk_sys);
      scl_high += i2c_pins.scl;
    end
    chk_out(scl_high, 0);
    chk_out(i2c_pins.sda, host_serial_in);
    #3;
    HOST.pulse(24 * hsp_pkg::GLITCH_CYC);
    chk_out(i2c_pins.scl, 1);
    repeat (20) @(posedge clk_sys);
    i2c_mode <= 0;
    repeat (8) @(posedge clk_sys);
    run(16, -9);
    chk_out(exp_q.size(), 0);
    stop_test();
  end
endmodule : tb_top

//--- logic/hsp_glitch_filter.sv
// spike filter: synchronises a pin and passes only stable levels
`timescale 1ns/1ps
module hsp_glitch_filter #(
  parameter int HOLD_CYC = hsp_pkg::GLITCH_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin in, clean level out
  input wire logic pin,
  output logic level
);
  logic sync_a;
  logic sync_b;
  logic [hsp_pkg::GLITCH_CNT_W-1:0] stable_cnt;

  // two-flop synchroniser
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // level follows only after it outlasted the full glitch width
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stable_cnt <= '0;
      level <= 1'b1;
    end else if (sync_b == level) begin
      stable_cnt <= '0;
    end else if (stable_cnt ==
                 hsp_pkg::GLITCH_CNT_W'(HOLD_CYC)) begin
      stable_cnt <= '0;
      level <= sync_b;
    end else begin
      stable_cnt <= stable_cnt + 1'b1;
    end
  end
endmodule : hsp_glitch_filter

//--- logic/hsp_host_port.sv
// serial host access port, slave side, with pin sharing for i2c
`timescale 1ns/1ps
// Overview of operation
// - host reads and writes device memory; port is spi or i2c slave
// - stopped serial clock, high or low, loses no bits or state
// - each completed 16-bit word goes to interpretation logic
// - first output bit driven at later of select fall, clock fall
// - command mode keeps select low across all command words
// - frame whose last word has other than 0 or 8 bits resets the slave
// - select may stay low across several back-to-back commands
// - select rising edge ends the sequence and resets the slave
// - serial output released after select deasserts
// - i2c mode reuses the same pins as the spi slave
// - i2c inputs ignore glitches up to 50 ns wide
module hsp_host_port (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // mode
  input wire logic i2c_mode,
  // host pins
  input wire logic host_clk,
  input wire logic host_chip_select_n,
  input wire logic host_serial_in,
  output logic host_serial_out,
  output logic host_serial_out_en,
  // received words towards the command interpreter
  output hsp_pkg::hsp_rx_t rx,
  output logic frame_abort,
  // words to send back
  input wire logic [15:0] tx_word,
  output logic tx_take,
  // filtered i2c pins for the i2c engine
  output hsp_pkg::hsp_i2c_pins_t i2c_pins
);
  // ----------------------------------------------------------------
  // link domain: runs on host_clk; framing and output state cleared while select is high
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] rx_word;
  logic bit_tgl;
  logic first_word;
  logic [15:0] tx_next;
  logic [15:0] tx_hold;
  logic [15:0] tx_first;
  logic out_q;
  logic drove;
  logic armed;
  logic [15:0] cur_word;

  // receive shift and bit count; select high clears framing state
  always_ff @(posedge host_clk or posedge host_chip_select_n) begin
    if (host_chip_select_n) begin
      bit_cnt <= hsp_pkg::BIT_ZERO;
      rx_shift <= hsp_pkg::WORD_RESET;
      first_word <= 1'b1;
    end else begin
      bit_cnt <= bit_cnt + 1'b1;
      rx_shift <= {rx_shift[14:0], host_serial_in};
      if (bit_cnt == hsp_pkg::WORD_LAST) begin
        first_word <= 1'b0;
      end
    end
  end

  // per-bit event and captured word, kept across frames
  always_ff @(posedge host_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_tgl <= 1'b0;
      rx_word <= hsp_pkg::WORD_RESET;
      tx_next <= hsp_pkg::WORD_RESET;
    end else if (!host_chip_select_n && !i2c_mode) begin
      bit_tgl <= ~bit_tgl;
      if (bit_cnt == hsp_pkg::WORD_LAST ||
          bit_cnt == hsp_pkg::BYTE_MARK - 4'h1) begin
        rx_word <= {rx_shift[14:0], host_serial_in};
      end
      if (bit_cnt == hsp_pkg::NEXT_FETCH) begin
        tx_next <= tx_hold; // tx_hold settled since bit 8
      end
    end
  end

  // first word stays frozen for the frame; later words come via tx_next
  assign cur_word = first_word ? tx_first : tx_next;

  // output bit changes on the falling clock edge
  always_ff @(negedge host_clk or posedge host_chip_select_n) begin
    if (host_chip_select_n) begin
      out_q <= 1'b0;
      drove <= 1'b0;
    end else begin
      out_q <= cur_word[~bit_cnt];
      drove <= ~i2c_mode;
    end
  end

  // select falling with clock low starts driving at once
  // kept for the whole frame so the pin never drops between edges
  always_ff @(negedge host_chip_select_n) begin
    armed <= ~host_clk & ~i2c_mode;
  end

  // drive while selected; select high releases the pin at once
  assign host_serial_out_en = drove |
    (armed & ~host_chip_select_n & ~i2c_mode);
  assign host_serial_out = drove ? out_q : cur_word[15];

  // ----------------------------------------------------------------
  // system domain: synchronisers
  // ----------------------------------------------------------------
  logic cs_a;
  logic cs_b;
  logic cs_c;
  logic tg_a;
  logic tg_b;
  logic tg_c;
  logic bit_evt;
  logic cs_rise;
  logic [3:0] sys_bits;
  hsp_pkg::hsp_state_t state;
  hsp_pkg::hsp_state_t next_state;

  // two flops per crossing level, then an edge-detect flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_a <= 1'b1;
      cs_b <= 1'b1;
      cs_c <= 1'b1;
      tg_a <= 1'b0;
      tg_b <= 1'b0;
      tg_c <= 1'b0;
    end else begin
      cs_a <= host_chip_select_n;
      cs_b <= cs_a;
      cs_c <= cs_b;
      tg_a <= bit_tgl;
      tg_b <= tg_a;
      tg_c <= tg_b;
    end
  end

  assign bit_evt = tg_b ^ tg_c;
  assign cs_rise = cs_b & ~cs_c;

  // ----------------------------------------------------------------
  // system domain: framing state
  // ----------------------------------------------------------------
  // mode and select decide whether spi framing runs
  always_comb begin
    next_state = state;
    case (state)
      hsp_pkg::HSP_OFF: begin
        if (!i2c_mode) next_state = hsp_pkg::HSP_IDLE;
      end
      hsp_pkg::HSP_IDLE: begin
        if (i2c_mode) next_state = hsp_pkg::HSP_OFF;
        else if (!cs_b) next_state = hsp_pkg::HSP_FRAME;
      end
      hsp_pkg::HSP_FRAME: begin
        if (cs_rise) next_state = hsp_pkg::HSP_IDLE;
      end
      default: next_state = hsp_pkg::HSP_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) state <= hsp_pkg::HSP_OFF;
    else state <= next_state;
  end

  // bit count within the word, word delivery, length check
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_bits <= hsp_pkg::BIT_ZERO;
      rx <= '0;
      frame_abort <= 1'b0;
    end else begin
      rx.valid <= 1'b0;
      frame_abort <= 1'b0;
      if (state == hsp_pkg::HSP_FRAME && cs_rise) begin
        sys_bits <= hsp_pkg::BIT_ZERO;
        if (sys_bits == hsp_pkg::BYTE_MARK) begin
          rx.valid <= 1'b1;
          rx.is_byte <= 1'b1;
          rx.data <= {8'h00, rx_word[7:0]};
        end else if (sys_bits != hsp_pkg::BIT_ZERO) begin
          frame_abort <= 1'b1;
        end
      end else if (state == hsp_pkg::HSP_FRAME && bit_evt) begin
        sys_bits <= sys_bits + 1'b1;
        if (sys_bits == hsp_pkg::WORD_LAST) begin
          rx.valid <= 1'b1;
          rx.is_byte <= 1'b0;
          rx.data <= rx_word;
        end
      end else if (state != hsp_pkg::HSP_FRAME) begin
        sys_bits <= hsp_pkg::BIT_ZERO;
      end
    end
  end

  // transmit word: follows input while idle, reloads mid-word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_hold <= hsp_pkg::WORD_RESET;
      tx_first <= hsp_pkg::WORD_RESET;
      tx_take <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (state == hsp_pkg::HSP_IDLE && cs_b) begin
        tx_hold <= tx_word;
        tx_first <= tx_word;
      end else if (state == hsp_pkg::HSP_FRAME && bit_evt &&
                   sys_bits == hsp_pkg::BYTE_MARK - 4'h1) begin
        tx_hold <= tx_word; // next word, taken by link at word end
        tx_take <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // i2c use of the shared pins
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_clean;

  assign pin_raw = {host_clk, host_serial_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      hsp_glitch_filter #(
        .HOLD_CYC(hsp_pkg::GLITCH_CYC)
      ) u_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(pin_raw[gi]),
        .level(pin_clean[gi])
      );
    end
  endgenerate

  // filtered levels reach the i2c engine only in i2c mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      i2c_pins <= '1;
    end else if (i2c_mode) begin
      i2c_pins.scl <= pin_clean[1];
      i2c_pins.sda <= pin_clean[0];
    end else begin
      i2c_pins <= '1;
    end
  end
endmodule : hsp_host_port
